// *** verilog/sfcp_pkg.sv ***
package sfcp_pkg;
    ////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int CLK_NS            = 50;
    localparam int CHIP_ERASE_US     = 1000;
    localparam int SECTOR_ERASE_US   = 200;
    localparam int PROG_US           = 5;
    // least times, rounded up to whole cycles
    localparam int CHIP_ERASE_CYC    = (CHIP_ERASE_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int SECTOR_ERASE_CYC  = (SECTOR_ERASE_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int PROG_CYC          = (PROG_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int LINK_PERIOD_NS    = 800;
    localparam int SCK_HALF_CYC      = LINK_PERIOD_NS / 2 / CLK_NS;

    ////////////////////////////////////////////////////////////////////////
    // link opcodes
    localparam logic [7:0] OP_WREN       = 8'h06;
    localparam logic [7:0] OP_WRDI       = 8'h04;
    localparam logic [7:0] OP_PDOWN      = 8'hB9;
    localparam logic [7:0] OP_ID_LEGACY  = 8'hAB;
    localparam logic [7:0] OP_ID_STD     = 8'h9F;
    localparam logic [7:0] OP_CERASE_A   = 8'h60;
    localparam logic [7:0] OP_CERASE_B   = 8'hC7;
    localparam logic [7:0] OP_SSERASE_A  = 8'h20;
    localparam logic [7:0] OP_SSERASE_B  = 8'hD7;
    localparam logic [7:0] OP_SERASE     = 8'hD8;
    localparam logic [7:0] OP_PROG       = 8'h02;
    localparam logic [7:0] OP_RD_STATUS  = 8'h05;
    localparam logic [7:0] OP_WR_STATUS  = 8'h01;

    ////////////////////////////////////////////////////////////////////////
    // protect_and_status layout
    localparam int ST_BUSY           = 0;
    localparam int ST_WEL            = 1;
    localparam int ST_BP0            = 2;
    localparam int ST_BP2            = 4;
    localparam int ST_TB             = 5;
    localparam int ST_LOCK           = 7;
    localparam logic [7:0] ST_NV_RST = 8'h00;

    // identity values, arbitrary
    localparam logic [7:0] ID_MFR    = 8'h5A;
    localparam logic [7:0] ID_TYPE   = 8'h3C;
    localparam logic [7:0] ID_CAP    = 8'h13;
    localparam logic [7:0] ID_RSVD   = 8'h00;
    localparam logic [7:0] ID_LEGACY = 8'h2E;

    ////////////////////////////////////////////////////////////////////////
    // host controller registers
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_TXDATA = 8'h04;
    localparam logic [7:0] REG_RXDATA = 8'h08;
    localparam logic [7:0] REG_PINS   = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam int CTRL_OP_LSB        = 0;
    localparam int CTRL_NTX_LSB       = 8;
    localparam int CTRL_NRX_LSB       = 11;
    localparam int CTRL_XBIT_LSB      = 14;
    localparam logic PINS_WP_RST      = 1'b1;

    typedef enum logic [1:0] {SFCP_RD_NONE, SFCP_RD_STD, SFCP_RD_LEGACY, SFCP_RD_STATUS} sfcp_rd_t;
endpackage : sfcp_pkg

// *** verilog/sfcp_link_if.sv ***
`timescale 1ns/1ns
interface sfcp_link_if;
    logic cs_n;
    logic sck;
    logic mosi;
    logic miso;
    logic wp_n;
    modport dev  (input cs_n, input sck, input mosi, input wp_n, output miso);
    modport host (output cs_n, output sck, output mosi, output wp_n, input miso);
endinterface : sfcp_link_if

// *** verilog/sfcp_sync.sv ***
`timescale 1ns/1ns
module sfcp_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // first stage is read only by the second
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            meta_q   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : sfcp_sync

// *** verilog/sfcp_flash_dev.sv ***
`timescale 1ns/1ns
module sfcp_flash_dev
    import sfcp_pkg::*;
#(
    parameter int CHIP_ERASE_CYCLES   = CHIP_ERASE_CYC,
    parameter int SECTOR_ERASE_CYCLES = SECTOR_ERASE_CYC
) (
    input  wire logic   sys_clk,
    input  wire logic   rstn,
    sfcp_link_if.dev    link,
    output logic [7:0]  status_q,
    output logic        power_down_q
);
    ////////////////////////////////////////////////////////////////////////
    // pin sampling
    logic [3:0] pins_s;
    logic       cs_n_s;
    logic       sck_s;
    logic       mosi_s;
    logic       wp_n_s;
    logic       sck_q;
    logic       cs_n_q;

    sfcp_sync #(.W(4)) u_sync (
        .sys_clk  (sys_clk),
        .rstn     (rstn),
        .async_in ({link.cs_n, link.sck, link.mosi, link.wp_n}),
        .sync_out (pins_s)
    );
    assign {cs_n_s, sck_s, mosi_s, wp_n_s} = pins_s;

    wire sck_rise = sck_s & ~sck_q & ~cs_n_s;
    wire sck_fall = ~sck_s & sck_q & ~cs_n_s;
    wire cs_rise  = cs_n_s & ~cs_n_q;

    ////////////////////////////////////////////////////////////////////////
    // state
    logic [2:0]  bit_cnt_q;
    logic [2:0]  byte_cnt_q;
    logic [7:0]  shreg_q;
    logic [7:0]  op_q;
    logic [23:0] addr_q;
    logic [7:0]  out_q;
    logic        miso_q;
    sfcp_rd_t    rd_q;
    logic [1:0]  id_idx_q;
    logic [23:0] timer_q;
    logic        wel_q;
    logic [2:0]  bp_q;
    logic        tb_q;
    logic        lock_q;

    function automatic logic is_protected(input logic [2:0] bp, input logic [18:0] a);
        logic hit;
        hit = 1'b0;
        if (bp[2])
            hit = 1'b1;
        else
            case (bp[1:0])
                2'b01:   hit = (a[18:16] == 3'h7);
                2'b10:   hit = (a[18:17] == 2'h3);
                2'b11:   hit = a[18];
                default: hit = 1'b0;
            endcase
        return hit;
    endfunction : is_protected

    function automatic logic [7:0] std_id(input logic [1:0] idx);
        logic [7:0] v;
        v = ID_MFR;
        case (idx)
            2'h1:    v = ID_TYPE;
            2'h2:    v = ID_CAP;
            2'h3:    v = ID_RSVD;
            default: v = ID_MFR;
        endcase
        return v;
    endfunction : std_id

    ////////////////////////////////////////////////////////////////////////
    // decoding
    wire        busy      = (timer_q != 24'h000000);
    wire [7:0]  sh_next   = {shreg_q[6:0], mosi_s};
    wire        byte_done = sck_rise & (bit_cnt_q == 3'h7);
    wire        first     = byte_done & (byte_cnt_q == 3'h0);
    // a partial byte at select release discards any write-type command
    wire        aligned   = (bit_cnt_q == 3'h0);
    wire        wr_ok     = cs_rise & aligned & ~power_down_q & ~busy & wel_q;
    wire        one_byte  = (byte_cnt_q == 3'h1);
    wire [7:0]  status_now = {lock_q, 1'b0, tb_q, bp_q, wel_q, busy};

    wire do_wren   = cs_rise & aligned & ~power_down_q & one_byte & (op_q == OP_WREN);
    wire do_wrdi   = cs_rise & aligned & ~power_down_q & one_byte & (op_q == OP_WRDI);
    wire do_pdown  = cs_rise & aligned & ~power_down_q & ~busy & one_byte & (op_q == OP_PDOWN);
    wire do_cerase = wr_ok & one_byte & ((op_q == OP_CERASE_A) | (op_q == OP_CERASE_B))
                     & (bp_q == 3'h0);
    wire is_serase = (op_q == OP_SSERASE_A) | (op_q == OP_SSERASE_B) | (op_q == OP_SERASE);
    wire do_serase = wr_ok & (byte_cnt_q == 3'h4) & is_serase & ~is_protected(bp_q, addr_q[18:0]);
    wire do_prog   = wr_ok & (byte_cnt_q >= 3'h5) & (op_q == OP_PROG)
                     & ~is_protected(bp_q, addr_q[18:0]);
    // exactly one data byte; two or more are discarded
    wire wr_status = wr_ok & (op_q == OP_WR_STATUS) & (byte_cnt_q == 3'h2);
    wire do_wrsr   = wr_status & ~(lock_q & ~wp_n_s);
    wire pd_exit   = first & (sh_next == OP_ID_LEGACY);
    wire start_std = first & (sh_next == OP_ID_STD) & ~busy & ~power_down_q;
    wire start_st  = first & (sh_next == OP_RD_STATUS) & ~power_down_q;
    wire start_leg = byte_done & (byte_cnt_q == 3'h3) & (op_q == OP_ID_LEGACY) & ~busy;

    ////////////////////////////////////////////////////////////////////////
    // byte framing
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            sck_q      <= 1'b0;
            cs_n_q     <= 1'b1;
            bit_cnt_q  <= 3'h0;
            byte_cnt_q <= 3'h0;
            shreg_q    <= 8'h00;
            op_q       <= 8'h00;
            addr_q     <= 24'h000000;
        end
        else
        begin
            sck_q  <= sck_s;
            cs_n_q <= cs_n_s;
            if (cs_n_s)
            begin
                bit_cnt_q  <= 3'h0;
                byte_cnt_q <= 3'h0;
            end
            else if (sck_rise)
            begin
                bit_cnt_q <= bit_cnt_q + 3'h1;
                shreg_q   <= sh_next;
                if (byte_done && byte_cnt_q != 3'h7)
                    byte_cnt_q <= byte_cnt_q + 3'h1;
                if (first)
                    op_q <= sh_next;
                if (byte_done && byte_cnt_q >= 3'h1 && byte_cnt_q <= 3'h3)
                    addr_q <= {addr_q[15:0], sh_next};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read-back shifter; loads at the rise of a byte's last bit (bit_cnt_q 7), first bit out on that fall
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            rd_q     <= SFCP_RD_NONE;
            out_q    <= 8'h00;
            id_idx_q <= 2'h0;
            miso_q   <= 1'b0;
        end
        else if (cs_n_s)
        begin
            rd_q   <= SFCP_RD_NONE;
            miso_q <= 1'b0;
        end
        else if (byte_done)
        begin
            if (start_std)
            begin
                rd_q     <= SFCP_RD_STD;
                out_q    <= std_id(2'h0);
                id_idx_q <= 2'h1;
            end
            else if (start_st)
            begin
                rd_q  <= SFCP_RD_STATUS;
                out_q <= status_now;
            end
            else if (start_leg)
            begin
                rd_q  <= SFCP_RD_LEGACY;
                out_q <= ID_LEGACY;
            end
            else
            begin
                case (rd_q)
                    SFCP_RD_STD:
                    begin
                        out_q    <= std_id(id_idx_q);
                        id_idx_q <= id_idx_q + 2'h1;
                    end
                    SFCP_RD_LEGACY: out_q <= ID_LEGACY;
                    SFCP_RD_STATUS: out_q <= status_now;
                    default:        out_q <= 8'h00;
                endcase
            end
        end
        else if (sck_fall && rd_q != SFCP_RD_NONE)
        begin
            miso_q <= out_q[7];
            out_q  <= {out_q[6:0], 1'b0};
        end
    end
    assign link.miso = miso_q;

    ////////////////////////////////////////////////////////////////////////
    // write latch, protection bits, power-down and the internal timer
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            wel_q        <= 1'b0;
            power_down_q <= 1'b0;
            timer_q      <= 24'h000000;
            bp_q         <= ST_NV_RST[ST_BP2:ST_BP0];
            tb_q         <= ST_NV_RST[ST_TB];
            lock_q       <= ST_NV_RST[ST_LOCK];
        end
        else
        begin
            if (do_wren)
                wel_q <= 1'b1;
            else if (do_wrdi || do_wrsr || do_cerase || do_serase || do_prog)
                wel_q <= 1'b0;
            if (do_pdown)
                power_down_q <= 1'b1;
            else if (pd_exit)
                power_down_q <= 1'b0;
            if (do_cerase)
                timer_q <= CHIP_ERASE_CYCLES[23:0];
            else if (do_serase)
                timer_q <= SECTOR_ERASE_CYCLES[23:0];
            else if (do_prog)
                timer_q <= PROG_CYC[23:0];
            else if (busy)
                timer_q <= timer_q - 24'h000001;
            if (do_wrsr)
            begin
                bp_q   <= shreg_q[ST_BP2:ST_BP0];
                tb_q   <= shreg_q[ST_TB];
                lock_q <= shreg_q[ST_LOCK];
            end
        end
    end

    // user-side copy of the status byte, one cycle behind
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            status_q <= ST_NV_RST;
        else
            status_q <= status_now;
    end
endmodule : sfcp_flash_dev

// *** verilog/sfcp_host_ctrl.sv ***
`timescale 1ns/1ns
module sfcp_host_ctrl
    import sfcp_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    sfcp_link_if.host        link,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp
);
    typedef enum logic [2:0] {H_IDLE, H_SETUP, H_SHIFT, H_HOLD, H_GAP} sfcp_hst_t;

    sfcp_hst_t   st_q;
    logic [4:0]  div_q;
    logic [6:0]  bits_q;
    logic [39:0] tx_q;
    logic [31:0] txdata_q;
    logic [31:0] rx_q;
    logic        wp_q;
    logic        cs_n_q;
    logic        sck_q;
    logic        mosi_q;
    logic        miso_s;
    logic        wr_pend_q;
    logic [7:0]  wr_addr_q;

    sfcp_sync #(.W(1)) u_sync (
        .sys_clk  (sys_clk),
        .rstn     (rstn),
        .async_in (link.miso),
        .sync_out (miso_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus slave: zero wait, always okay
    wire        addr_ph  = hsel & htrans[1] & hready;
    wire        wr_ctrl  = wr_pend_q & (wr_addr_q == REG_CTRL) & (st_q == H_IDLE);
    wire [2:0]  ntx      = hwdata[CTRL_NTX_LSB +: 3];
    wire [2:0]  nrx      = hwdata[CTRL_NRX_LSB +: 3];
    wire [6:0]  nbits    = {1'b0, ntx, 3'h0} + {1'b0, nrx, 3'h0} + 7'h08 + {4'h0, hwdata[CTRL_XBIT_LSB +: 3]};
    wire        half_end = (div_q == 5'(SCK_HALF_CYC - 1));
    wire        full_end = (div_q == 5'(2 * SCK_HALF_CYC - 1));
    wire [31:0] rd_mux   = (haddr[7:0] == REG_TXDATA) ? txdata_q :
                           (haddr[7:0] == REG_RXDATA) ? rx_q :
                           (haddr[7:0] == REG_PINS)   ? {31'h0, wp_q} :
                           (haddr[7:0] == REG_STATUS) ? {31'h0, st_q != H_IDLE} : 32'h0;

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata    <= 32'h0;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
            txdata_q  <= 32'h0;
            wp_q      <= PINS_WP_RST;
        end
        else
        begin
            hreadyout <= 1'b1;
            wr_pend_q <= addr_ph & hwrite;
            wr_addr_q <= haddr[7:0];
            if (addr_ph && !hwrite)
                hrdata <= rd_mux;
            if (wr_pend_q && wr_addr_q == REG_TXDATA)
                txdata_q <= hwdata;
            if (wr_pend_q && wr_addr_q == REG_PINS)
                wp_q <= hwdata[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link sequencer, mode 0: data changes on fall, sampled on rise
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            st_q   <= H_IDLE;
            div_q  <= 5'h00;
            bits_q <= 7'h00;
            tx_q   <= 40'h0;
            rx_q   <= 32'h0;
            cs_n_q <= 1'b1;
            sck_q  <= 1'b0;
            mosi_q <= 1'b0;
        end
        else
        begin
            div_q <= div_q + 5'h01;
            case (st_q)
                H_IDLE:
                    if (wr_ctrl)
                    begin
                        // opcode, then tx bytes high first, then zeros as dummies
                        tx_q   <= {hwdata[CTRL_OP_LSB +: 8], txdata_q};
                        bits_q <= nbits;
                        cs_n_q <= 1'b0;
                        mosi_q <= hwdata[CTRL_OP_LSB + 7];
                        div_q  <= 5'h00;
                        st_q   <= H_SETUP;
                    end
                H_SETUP:
                    if (half_end)
                    begin
                        div_q <= 5'h00;
                        st_q  <= H_SHIFT;
                    end
                H_SHIFT:
                begin
                    if (half_end)
                    begin
                        sck_q <= 1'b1;
                        rx_q  <= {rx_q[30:0], miso_s};
                    end
                    if (full_end)
                    begin
                        sck_q  <= 1'b0;
                        div_q  <= 5'h00;
                        tx_q   <= {tx_q[38:0], 1'b0};
                        mosi_q <= tx_q[38];
                        bits_q <= bits_q - 7'h01;
                        if (bits_q == 7'h01)
                            st_q <= H_HOLD;
                    end
                end
                H_HOLD:
                    if (half_end)
                    begin
                        cs_n_q <= 1'b1;
                        div_q  <= 5'h00;
                        st_q   <= H_GAP;
                    end
                H_GAP:
                    if (half_end)
                        st_q <= H_IDLE;
                default: st_q <= H_IDLE;
            endcase
        end
    end

    assign link.cs_n = cs_n_q;
    assign link.sck  = sck_q;
    assign link.mosi = mosi_q;
    assign link.wp_n = wp_q;
endmodule : sfcp_host_ctrl

// *** bench/sfcp_link_properties.sv ***
`timescale 1ns/1ns
module sfcp_link_properties #(
    parameter int BUSY_MAX = 4050
) (
    input wire logic       sys_clk,
    input wire logic       rstn,
    input wire logic       cs_n,
    input wire logic       sck,
    input wire logic       wp_n,
    input wire logic [7:0] status_q,
    input wire logic       power_down_q
);
    logic [15:0] busy_cnt_q;
    logic [15:0] busy_cnt_d;
    logic [3:0]  wp_low_q;
    logic [3:0]  wp_low_d;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////////
    // helper counters: busy length, and how long the protect pin has been low
    assign busy_cnt_d = status_q[0] ? busy_cnt_q + 16'h0001 : 16'h0000;
    assign wp_low_d   = wp_n ? 4'h0 : ((wp_low_q == 4'hF) ? wp_low_q : wp_low_q + 4'h1);

    always_ff @(posedge sys_clk)
    begin
        busy_cnt_q <= rstn ? busy_cnt_d : 16'h0000;
        wp_low_q   <= rstn ? wp_low_d : 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    sequence setup_s;
        !sck [*8];
    endsequence

    sck_idle_a: assert property (cs_n |-> !sck)
        else $error("link clock moved while deselected");
    frame_setup_a: assert property ($fell(cs_n) |-> setup_s)
        else $error("link clock edge too soon after select");
    bit_six_a: assert property (!status_q[6])
        else $error("reserved status bit set");
    latch_at_cs_a: assert property ($changed(status_q[1]) |-> cs_n)
        else $error("write latch changed inside a frame");
    busy_needs_wel_a: assert property ($rose(status_q[0]) |-> $past(status_q[1], 3))
        else $error("internal write started without write latch");
    busy_bound_a: assert property (busy_cnt_q <= BUSY_MAX)
        else $error("busy flag held too long");
    pd_not_busy_a: assert property ($rose(power_down_q) |-> !status_q[0])
        else $error("power-down entered while busy");
    pd_exit_a: assert property ($fell(power_down_q) |-> !cs_n)
        else $error("power-down left outside a frame");
    lock_hold_a: assert property ((wp_low_q > 4'h7 && status_q[7]) |=> $stable(status_q[7:2]))
        else $error("locked protect bits changed");
endmodule : sfcp_link_properties

// *** bench/tb_serial_flash_cmd_protect.sv ***
`timescale 1ns/1ns
module tb_serial_flash_cmd_protect
    import sfcp_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        rstn    = 1'b0;
    logic        hsel    = 1'b0;
    logic [31:0] haddr   = 32'h0;
    logic [1:0]  htrans  = 2'h0;
    logic        hwrite  = 1'b0;
    logic [2:0]  hsize   = 3'h2;
    logic [31:0] hwdata  = 32'h0;
    logic        hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [7:0]  status_q;
    logic        power_down_q;
    logic [31:0] rd_q;
    int          mismatches  = 0;
    int          checks_done = 0;
    int          cycles      = 0;

    always #25 sys_clk = ~sys_clk;
    assign hready = hreadyout;

    sfcp_link_if link ();
    sfcp_flash_dev #(.CHIP_ERASE_CYCLES(4000), .SECTOR_ERASE_CYCLES(100)) i_sfcp_flash_dev (
        .sys_clk(sys_clk), .rstn(rstn), .link(link), .status_q(status_q), .power_down_q(power_down_q));
    sfcp_host_ctrl i_sfcp_host_ctrl (
        .sys_clk(sys_clk), .rstn(rstn), .link(link), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp));
    sfcp_link_properties #(.BUSY_MAX(4050)) i_sfcp_link_properties (
        .sys_clk(sys_clk), .rstn(rstn), .cs_n(link.cs_n), .sck(link.sck), .wp_n(link.wp_n),
        .status_q(status_q), .power_down_q(power_down_q));

    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        if (mismatches == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // values read here are those sampled at this rising edge, before the design's flops update
    task automatic wait_ready;
        do @(posedge sys_clk); while (hready !== 1'b1);
        rd_q = hrdata;
    endtask : wait_ready

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        r = rd_q;
        check({31'h0, hresp}, 32'h0);
    endtask : bus

    task automatic frame(input logic [7:0] o, input logic [2:0] ntx, input logic [2:0] nrx,
                         input logic [2:0] xb, input logic [31:0] tx);
        logic [31:0] r;
        bus(REG_TXDATA, 1'b1, tx, r);
        bus(REG_CTRL, 1'b1, {15'h0, xb, nrx, ntx, o}, r);
        r = 32'h1;
        while (r[0] === 1'b1) bus(REG_STATUS, 1'b0, 32'h0, r);
    endtask : frame

    task automatic op(input logic [7:0] o);
        frame(o, 3'd0, 3'd0, 3'd0, 32'h0);
    endtask : op

    task automatic sw(input logic [7:0] v, input logic [2:0] n, input logic [2:0] xb);
        frame(OP_WR_STATUS, n, 3'd0, xb, {v, v, v, v});
    endtask : sw

    task automatic rd_st(output logic [7:0] s);
        logic [31:0] r;
        frame(OP_RD_STATUS, 3'd0, 3'd1, 3'd0, 32'h0);
        bus(REG_RXDATA, 1'b0, 32'h0, r);
        s = r[7:0];
    endtask : rd_st

    task automatic cst(input logic [7:0] exp);
        logic [7:0] s;
        rd_st(s);
        check({24'h0, s}, {24'h0, exp});
    endtask : cst

    task automatic wp(input logic v);
        logic [31:0] r;
        bus(REG_PINS, 1'b1, {31'h0, v}, r);
    endtask : wp

    ////////////////////////////////////////////////////////////////////////
    task automatic t_latch;
        op(OP_WREN);
        cst(8'h02);
        op(OP_WRDI);
        cst(8'h00);
        op(OP_WREN);
        sw(8'hFF, 3'd1, 3'd0);
        cst(8'hBC);
    endtask : t_latch

    task automatic t_protect;
        op(OP_WREN);
        op(OP_CERASE_A);
        cst(8'hBE);
        wp(1'b0);
        sw(8'h00, 3'd1, 3'd0);
        cst(8'hBE);
        wp(1'b1);
        sw(8'h00, 3'd1, 3'd0);
        cst(8'h00);
        op(OP_WREN);
        sw(8'h1C, 3'd2, 3'd0);
        sw(8'h1C, 3'd1, 3'd3);
        cst(8'h02);
        op(OP_WRDI);
        sw(8'h1C, 3'd1, 3'd0);
        op(OP_CERASE_B);
        cst(8'h00);
    endtask : t_protect

    task automatic t_erase(input logic [7:0] o);
        logic [7:0]  s;
        logic [31:0] r;
        int          n;
        op(OP_WREN);
        op(o);
        rd_st(s);
        check({31'h0, s[0]}, 32'h1);
        frame(OP_ID_STD, 3'd0, 3'd4, 3'd0, 32'h0);
        bus(REG_RXDATA, 1'b0, 32'h0, r);
        check(r, 32'h0);
        op(OP_PDOWN);
        check({31'h0, power_down_q}, 32'h0);
        n = 0;
        do
        begin
            rd_st(s);
            n++;
        end
        while (s[0] === 1'b1 && n < 40);
        check({24'h0, s}, 32'h0);
    endtask : t_erase

    task automatic t_id;
        logic [31:0] r;
        // one dummy byte first, so the last word shows the four-byte cycle wrapping round
        frame(OP_ID_STD, 3'd1, 3'd4, 3'd0, 32'h0);
        bus(REG_RXDATA, 1'b0, 32'h0, r);
        check(r, {ID_TYPE, ID_CAP, ID_RSVD, ID_MFR});
        frame(OP_ID_LEGACY, 3'd3, 3'd2, 3'd0, 32'h0);
        bus(REG_RXDATA, 1'b0, 32'h0, r);
        check(r, {16'h0, ID_LEGACY, ID_LEGACY});
    endtask : t_id

    task automatic t_pd;
        op(OP_PDOWN);
        check({31'h0, power_down_q}, 32'h1);
        op(OP_WREN);
        check({31'h0, status_q[1]}, 32'h0);
        op(OP_ID_LEGACY);
        check({31'h0, power_down_q}, 32'h0);
        cst(8'h00);
    endtask : t_pd

    task automatic t_prog;
        op(OP_WREN);
        // three stray bits after the data byte: discarded, latch kept
        frame(OP_PROG, 3'h4, 3'h0, 3'h3, 32'h000000A5);
        cst(8'h02);
        frame(OP_PROG, 3'h4, 3'h0, 3'h0, 32'h000000A5);
        cst(8'h00);
        op(OP_WREN);
        sw(8'h04, 3'h1, 3'h0);
        cst(8'h04);
        op(OP_WREN);
        // sector in the protected top eighth is refused
        frame(OP_SERASE, 3'h3, 3'h0, 3'h0, 32'h07000000);
        cst(8'h06);
        sw(8'h00, 3'h1, 3'h0);
        cst(8'h00);
    endtask : t_prog

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        t_latch();
        t_protect();
        t_prog();
        t_erase(OP_CERASE_B);
        t_erase(OP_CERASE_A);
        t_id();
        t_pd();
        print_verdict();
    end
endmodule : tb_serial_flash_cmd_protect
